// ===== core/tro_pkg.sv
// Package for the tone and ringing oscillator control block.
// Assumes a 25 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package tro_pkg;

  localparam int ADDR_W = 12;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_TONE_ONE_CTRL = 8'h20;
  localparam logic [7:0] IDX_TONE_TWO_CTRL = 8'h21;
  localparam logic [7:0] IDX_RINGER_CTRL = 8'h22;
  localparam logic [7:0] IDX_TIMER_BASE = 8'h24;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h2c;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h2d;
  localparam logic [7:0] IDX_RINGER_RUN = 8'h2e;
  localparam int NUM_TIMERS = 6;

  // Control register fields
  localparam int BIT_ACTIVE = 7;
  localparam int BIT_REPEAT = 6;
  localparam int BIT_ZERO_CROSS = 5;
  localparam int BIT_RING_LINE = 5;
  localparam int BIT_ON_TIMER_EN = 4;
  localparam int BIT_OFF_TIMER_EN = 3;
  localparam int BIT_ENABLE = 2;
  localparam int BIT_DC_BIAS = 1;
  localparam int BIT_WAVE_SHAPE = 0;
  localparam int BIT_ROUTE_TX = 0;
  localparam int BIT_ROUTE_RX = 1;

  // Writable bits of each control register
  localparam logic [7:0] TONE_ONE_WMASK = 8'h7f;
  localparam logic [7:0] TONE_TWO_WMASK = 8'h3f;
  localparam logic [7:0] RINGER_WMASK = 8'h1b;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [5:0] IRQ_RST = 6'h00;

  // Cadence timer resolution
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 125000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ON,
    ST_ZERO_WAIT,
    ST_OFF,
    ST_DONE
  } tro_state_e;

endpackage

// ===== core/tro_ctrl.sv
// Control and status for two tone oscillators and the ringing oscillator.
// Assumes the synthesis datapath reports zero crossings and dc-feed crossings as inputs.
// Function
// RULE1: tone control bit 7 reads back whether that tone output is active.
// RULE2: tone one stops after off interval unless repeat bit 6 is set.
// RULE3: host should set tone one repeat when used for caller-id signalling.
// RULE4: tone one zero-cross bit 5 delays stop to first zero crossing after expiry.
// RULE5: tone two zero-cross bit 5 delays stop to a zero crossing.
// RULE6: bit 4 runs the on timer, bit 3 runs the off timer.
// RULE7: tone generates output only while enable bit 2 is one.
// RULE8: route bits 1:0 select none, transmit, receive or both paths.
// RULE9: tone two and ringer control bit 6 read as zero.
// RULE10: ringer control bit 7 reads back whether ringing output is active.
// RULE11: line drive waits for dc-feed continuity; bit 5 shows ringing on line.
// RULE12: ringer bit 4 runs its on timer, bit 3 its off timer.
// RULE13: ringer control bit 2 reads whether the ringer is enabled.
// RULE14: ringer bit 1 adds dc offset to the ringing waveform.
// RULE15: ringer bit 0 selects sinusoid (0) or trapezoid (1).
// RULE16: ringer timers are sixteen bits counting 125 us steps.
// RULE17: each on and off timer expiry raises a maskable interrupt.
// RULE18: with both timers on, output alternates on and off while enabled.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns

module tro_ctrl
  import tro_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic tone_one_zero_cross_i,
  input wire logic tone_two_zero_cross_i,
  input wire logic ring_dc_cross_i,
  output logic [2:0] osc_active_o,
  output logic [1:0] tone_tx_o,
  output logic [1:0] tone_rx_o,
  output logic ring_on_line_o,
  output logic ringer_dc_bias_o,
  output logic wave_shape_sel_o,
  output logic irq_o
);

  localparam int TW = $clog2(TICK_DIV + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);

  typedef struct packed {
    logic [2:0][7:0] ctrl;
    logic [NUM_TIMERS-1:0][15:0] tmr;
    logic ring_run;
    logic [5:0] irq_stat;
    logic [5:0] irq_mask;
    tro_state_e [2:0] st;
    logic [2:0][15:0] cnt;
    logic ring_line;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] o_active;
    logic [1:0] o_tx;
    logic [1:0] o_rx;
    logic o_line;
    logic o_bias;
    logic o_wave;
    logic o_irq;
  } tro_state_s;

  tro_state_s s;
  tro_state_s next_s;

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] addr);
    logic [7:0] i;
    i = addr[9:2];
    addr_ok = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:10] == '0) &&
      ((i >= IDX_TONE_ONE_CTRL && i <= IDX_RINGER_CTRL) ||
       (i >= IDX_TIMER_BASE && i < IDX_TIMER_BASE + 8'(NUM_TIMERS)) ||
       i == IDX_IRQ_STATUS || i == IDX_IRQ_MASK || i == IDX_RINGER_RUN);
  endfunction

  always_comb begin
    logic [2:0] en;
    logic [2:0] on_te;
    logic [2:0] off_te;
    logic [2:0] zc_stop;
    logic [2:0] zc_seen;
    logic [2:0] rep;
    logic [5:0] irq_set;
    logic [5:0] irq_clr;
    logic [7:0] idx;
    logic [31:0] rd;
    logic [2:0] act;
    next_s = s;
    irq_set = '0;
    irq_clr = '0;
    idx = '0;
    rd = '0;
    act = '0;
    en = '0;
    on_te = '0;
    off_te = '0;
    zc_stop = '0;
    zc_seen = '0;
    rep = '0;

    // Shared 125 us time base for all cadence timers
    next_s.tick = 1'b0;
    if (s.tick_cnt == '0) begin
      next_s.tick_cnt = TICK_LAST;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt - 1'b1;
    end

    for (int c = 0; c < 3; c++) begin
      en[c] = (c == 2) ? s.ring_run : s.ctrl[c][BIT_ENABLE];
      on_te[c] = s.ctrl[c][BIT_ON_TIMER_EN];
      off_te[c] = s.ctrl[c][BIT_OFF_TIMER_EN];
      zc_stop[c] = (c == 2) ? 1'b0 : s.ctrl[c][BIT_ZERO_CROSS];
      rep[c] = (c == 0) ? s.ctrl[0][BIT_REPEAT] : 1'b1;
    end
    zc_seen = {1'b0, tone_two_zero_cross_i, tone_one_zero_cross_i};

    // Cadence sequencer per oscillator
    for (int c = 0; c < 3; c++) begin
      if (!en[c]) begin
        next_s.st[c] = ST_IDLE; // RULE7
      end else begin
        unique case (s.st[c])
          ST_IDLE: begin
            next_s.st[c] = ST_ON;
            next_s.cnt[c] = s.tmr[2*c];
          end
          ST_ON: begin
            if (on_te[c] && s.tick) begin // RULE6 RULE12 RULE16
              if (s.cnt[c] <= 16'h0001) begin
                irq_set[2*c] = 1'b1; // RULE17
                if (zc_stop[c]) begin
                  next_s.st[c] = ST_ZERO_WAIT; // RULE4 RULE5
                end else begin
                  next_s.st[c] = ST_OFF;
                  next_s.cnt[c] = s.tmr[2*c+1];
                end
              end else begin
                next_s.cnt[c] = s.cnt[c] - 16'h0001;
              end
            end
          end
          ST_ZERO_WAIT: begin
            if (zc_seen[c]) begin // RULE4 RULE5
              next_s.st[c] = ST_OFF;
              next_s.cnt[c] = s.tmr[2*c+1];
            end
          end
          ST_OFF: begin
            if (off_te[c] && s.tick) begin // RULE6 RULE12 RULE16
              if (s.cnt[c] <= 16'h0001) begin
                irq_set[2*c+1] = 1'b1; // RULE17
                if (rep[c]) begin
                  next_s.st[c] = ST_ON; // RULE2 RULE18
                  next_s.cnt[c] = s.tmr[2*c];
                end else begin
                  next_s.st[c] = ST_DONE; // RULE2
                end
              end else begin
                next_s.cnt[c] = s.cnt[c] - 16'h0001;
              end
            end
          end
          ST_DONE: begin
            next_s.st[c] = ST_DONE;
          end
        endcase
      end
      act[c] = (s.st[c] == ST_ON) || (s.st[c] == ST_ZERO_WAIT);
    end

    // Ringing reaches the line only at a dc-feed crossing, both at start and stop
    if (ring_dc_cross_i && (act[2] != s.ring_line)) begin
      next_s.ring_line = act[2]; // RULE11
    end

    // Write channel: address and data may arrive in either order
    if (s.aw_rdy && s_axi_awvalid_i) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr_i;
    end
    if (s.w_rdy && s_axi_wvalid_i) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata_i;
      next_s.wstrb = s_axi_wstrb_i;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = addr_ok(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      idx = reg_index(s.awaddr);
      if (addr_ok(s.awaddr) && s.wstrb[0]) begin
        if (idx == IDX_TONE_ONE_CTRL) begin
          next_s.ctrl[0] = s.wdata[7:0] & TONE_ONE_WMASK;
        end
        if (idx == IDX_TONE_TWO_CTRL) begin
          next_s.ctrl[1] = s.wdata[7:0] & TONE_TWO_WMASK;
        end
        if (idx == IDX_RINGER_CTRL) begin
          next_s.ctrl[2] = s.wdata[7:0] & RINGER_WMASK;
        end
        if (idx == IDX_IRQ_STATUS) begin
          irq_clr = s.wdata[5:0];
        end
        if (idx == IDX_IRQ_MASK) begin
          next_s.irq_mask = s.wdata[5:0];
        end
        if (idx == IDX_RINGER_RUN) begin
          next_s.ring_run = s.wdata[0];
        end
      end
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (addr_ok(s.awaddr) && idx == IDX_TIMER_BASE + 8'(t)) begin
          if (s.wstrb[0]) begin
            next_s.tmr[t][7:0] = s.wdata[7:0];
          end
          if (s.wstrb[1]) begin
            next_s.tmr[t][15:8] = s.wdata[15:8];
          end
        end
      end
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end

    // Set wins over a simultaneous write-one clear
    next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_set; // RULE17

    // Read channel
    if (s.ar_rdy && s_axi_arvalid_i) begin
      idx = reg_index(s_axi_araddr_i);
      if (idx == IDX_TONE_ONE_CTRL) begin
        rd[7:0] = {act[0], s.ctrl[0][6:0]}; // RULE1
      end
      if (idx == IDX_TONE_TWO_CTRL) begin
        rd[7:0] = {act[1], 1'b0, s.ctrl[1][5:0]}; // RULE1 RULE9
      end
      if (idx == IDX_RINGER_CTRL) begin
        rd[7:0] = {act[2], 1'b0, s.ring_line, s.ctrl[2][4:3], s.ring_run,
          s.ctrl[2][1:0]}; // RULE10 RULE11 RULE13 RULE9
      end
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (idx == IDX_TIMER_BASE + 8'(t)) begin
          rd[15:0] = s.tmr[t];
        end
      end
      if (idx == IDX_IRQ_STATUS) begin
        rd[5:0] = s.irq_stat;
      end
      if (idx == IDX_IRQ_MASK) begin
        rd[5:0] = s.irq_mask;
      end
      if (idx == IDX_RINGER_RUN) begin
        rd[0] = s.ring_run;
      end
      if (!addr_ok(s_axi_araddr_i)) begin
        rd = '0;
      end
      next_s.rdata = rd;
      next_s.rresp = addr_ok(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      next_s.rvalid = 1'b1;
    end
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end

    next_s.aw_rdy = !next_s.aw_got && !next_s.bvalid;
    next_s.w_rdy = !next_s.w_got && !next_s.bvalid;
    next_s.ar_rdy = !next_s.rvalid;

    // Registered outputs, one cycle behind the sequencer, except irq_o which updates together with irq_stat
    next_s.o_active = act;
    for (int c = 0; c < 2; c++) begin
      next_s.o_tx[c] = act[c] && s.ctrl[c][BIT_ROUTE_TX]; // RULE8
      next_s.o_rx[c] = act[c] && s.ctrl[c][BIT_ROUTE_RX]; // RULE8
    end
    next_s.o_line = s.ring_line; // RULE11
    next_s.o_bias = s.ctrl[2][BIT_DC_BIAS]; // RULE14
    next_s.o_wave = s.ctrl[2][BIT_WAVE_SHAPE]; // RULE15
    next_s.o_irq = |(next_s.irq_stat & next_s.irq_mask); // RULE17
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.ctrl <= {3{CTRL_RST}};
      s.tmr <= {NUM_TIMERS{TIMER_RST}};
      s.irq_stat <= IRQ_RST;
      s.irq_mask <= IRQ_RST;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready_o = s.aw_rdy;
  assign s_axi_wready_o = s.w_rdy;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_arready_o = s.ar_rdy;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = s.rresp;
  assign s_axi_rvalid_o = s.rvalid;
  assign osc_active_o = s.o_active;
  assign tone_tx_o = s.o_tx;
  assign tone_rx_o = s.o_rx;
  assign ring_on_line_o = s.o_line;
  assign ringer_dc_bias_o = s.o_bias;
  assign wave_shape_sel_o = s.o_wave;
  assign irq_o = s.o_irq;

endmodule

// ===== test/tro_ctrl_props.sv
// Bus handshake and line-drive checks for tro_ctrl.
// Sees only the top ports; bound into every tro_ctrl.
`timescale 1ns/1ns
module tro_ctrl_props #(
  parameter int TICK_DIV = 3125
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic ring_dc_cross_i,
  input wire logic ring_on_line_o,
  input wire logic [2:0] osc_active_o,
  input wire logic [1:0] tone_tx_o,
  input wire logic [1:0] tone_rx_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  a_b_follows: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("no write response");
  a_r_follows: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("no read response");
  a_b_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped");
  a_r_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read data not held");
  a_aw_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during response");
  a_line_at_cross: assert property (
    $changed(ring_on_line_o) |-> $past(ring_dc_cross_i, 2)) else $error("line switched off cross");
  a_line_needs_ring: assert property (
    $rose(ring_on_line_o) |-> osc_active_o[2] || $past(osc_active_o[2]))
    else $error("line drive without ringer");
  a_route_gate: assert property (
    !(|((tone_tx_o | tone_rx_o) & ~(osc_active_o[1:0] | $past(osc_active_o[1:0])))))
    else $error("routed tone while idle");
endmodule
bind tro_ctrl tro_ctrl_props #(.TICK_DIV(TICK_DIV)) u_tro_ctrl_props (.*);

// ===== test/tro_wave_model.sv
// Datapath stand-in: zero-crossing and dc-feed crossing strobes.
// Strobes only while run_i is high, so the bench can hold a crossing back.
`timescale 1ns/1ns
module tro_wave_model (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  output logic zc_one_o,
  output logic zc_two_o,
  output logic dc_cross_o
);
  logic [2:0] ph;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ph <= 3'h0;
      {zc_one_o, zc_two_o, dc_cross_o} <= 3'h0;
    end else begin
      ph <= (ph == 3'h6) ? 3'h0 : ph + 3'h1;
      zc_one_o <= run_i && ph == 3'h0;
      zc_two_o <= run_i && ph == 3'h3;
      dc_cross_o <= run_i && ph == 3'h5;
    end
  end
endmodule

// ===== test/testbench.sv
// Self-checking bench for tro_ctrl over AXI4-Lite.
// Timer tick shortened to 4 clocks so cadences fit in a short run.
`timescale 1ns/1ns
module testbench;
  import tro_pkg::*;
  logic mclk_i = 0, reset_n_i = 0, zc_run = 0;
  logic [ADDR_W-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, tone_tx_o, tone_rx_o;
  logic [2:0] osc_active_o;
  logic tone_one_zero_cross_i, tone_two_zero_cross_i, ring_dc_cross_i;
  logic ring_on_line_o, ringer_dc_bias_o, wave_shape_sel_o, irq_o;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  always #20 mclk_i = ~mclk_i;
  tro_ctrl #(.TICK_DIV(4)) u_tro_ctrl (.*);
  tro_wave_model u_tro_wave_model (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .run_i(zc_run),
    .zc_one_o(tone_one_zero_cross_i), .zc_two_o(tone_two_zero_cross_i),
    .dc_cross_o(ring_dc_cross_i));
  task automatic conclude;
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Run ceiling; the whole sequence needs about 600 cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      conclude;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    bit ad = 0, wd = 0, bd = 0;
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    while (!bd) begin
      @(posedge mclk_i);
      if (!ad && s_axi_awready_o) begin
        ad = 1;
        s_axi_awvalid_i <= 0;
      end
      if (!wd && s_axi_wready_o) begin
        wd = 1;
        s_axi_wvalid_i <= 0;
      end
      if (s_axi_bvalid_o) begin
        bd = 1;
        s_axi_bready_i <= 0;
        chk("bresp", er, s_axi_bresp_o);
      end
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    bit rdn = 0;
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    while (!rdn) begin
      @(posedge mclk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
      if (s_axi_rvalid_o) begin
        rdn = 1;
        s_axi_rready_i <= 0;
        chk("rresp", er, s_axi_rresp_o);
        chk("rdata", e, s_axi_rdata_o);
      end
    end
  endtask
  task automatic wirq;
    int i = 0;
    while (irq_o !== 1'b1 && i < 100) begin
      @(posedge mclk_i);
      i++;
    end
    chk("irq", 1, irq_o);
  endtask
  task automatic s_regs;
    wr(12'h080, 32'hfb);
    rd(12'h080, 32'h7b);
    wr(12'h084, 32'hfb);
    rd(12'h084, 32'h3b);
    wr(12'h088, 32'hff);
    rd(12'h088, 32'h1b);
    chk("shape", 3, {ringer_dc_bias_o, wave_shape_sel_o});
    wr(12'h088, 0);
    rd(12'h088, 0);
    chk("shape", 0, {ringer_dc_bias_o, wave_shape_sel_o});
    wr(12'h0a0, 32'h1ffff);
    rd(12'h0a0, 32'hffff);
    wr(12'h0fc, 1, RESP_SLVERR);
    rd(12'h0fc, 0, RESP_SLVERR);
  endtask
  task automatic s_route;
    logic [11:0] a;
    for (int t = 0; t < 2; t++) begin
      a = 12'h080 + 12'(4 * t);
      for (int c = 0; c < 4; c++) begin
        wr(a, 32'h4 | c);
        repeat (3) @(posedge mclk_i);
        chk("tx", c[0], tone_tx_o[t]);
        chk("rx", c[1], tone_rx_o[t]);
        chk("act", 1, osc_active_o[t]);
        rd(a, 32'h84 | c);
        wr(a, 0);
        repeat (3) @(posedge mclk_i);
        chk("idle", 0, {tone_tx_o, tone_rx_o, osc_active_o});
      end
    end
  endtask
  task automatic s_cadence;
    int n = 0;
    logic p;
    wr(12'h090, 2);
    wr(12'h094, 2);
    wr(12'h0b4, 1);
    wr(12'h080, 32'h1c);
    wirq;
    repeat (2) @(posedge mclk_i);
    chk("t1 stop", 0, osc_active_o[0]);
    repeat (40) @(posedge mclk_i);
    chk("t1 done", 0, osc_active_o[0]);
    rd(12'h0b0, 3);
    wr(12'h0b0, 1);
    repeat (2) @(posedge mclk_i);
    chk("irq clr", 0, irq_o);
    rd(12'h0b0, 2);
    // A finished tone stays silent until its enable is cleared
    wr(12'h080, 0);
    // Repeat set, as a caller-signalling host would
    wr(12'h080, 32'h5c);
    p = osc_active_o[0];
    repeat (120) begin
      @(posedge mclk_i);
      if (osc_active_o[0] && !p) n++;
      p = osc_active_o[0];
    end
    chk("bursts", 1, n >= 4);
    wr(12'h080, 0);
    wr(12'h0b0, 32'h3f);
  endtask
  task automatic s_zero;
    for (int t = 0; t < 2; t++) begin
      wr(12'h0b4, 32'h1 << (2 * t));
      wr(12'h090 + 12'(8 * t), 2);
      wr(12'h080 + 12'(4 * t), 32'h34);
      wirq;
      repeat (20) @(posedge mclk_i);
      chk("zc hold", 1, osc_active_o[t]);
      zc_run <= 1;
      repeat (12) @(posedge mclk_i);
      chk("zc stop", 0, osc_active_o[t]);
      zc_run <= 0;
      wr(12'h080 + 12'(4 * t), 0);
      wr(12'h0b0, 32'h3f);
    end
    wr(12'h0b4, 0);
  endtask
  task automatic s_ring;
    zc_run <= 1;
    wr(12'h0b8, 1);
    repeat (12) @(posedge mclk_i);
    chk("ring", 1, osc_active_o[2]);
    chk("line", 1, ring_on_line_o);
    rd(12'h088, 32'ha4);
    rd(12'h0b0, 0);
    zc_run <= 0;
    wr(12'h0b8, 0);
    repeat (10) @(posedge mclk_i);
    chk("line held", 1, ring_on_line_o);
    zc_run <= 1;
    repeat (10) @(posedge mclk_i);
    chk("line off", 0, ring_on_line_o);
    rd(12'h088, 0);
    // Ringer cadence with both timers running
    wr(12'h0a0, 2);
    wr(12'h0b4, 32'h10);
    wr(12'h088, 32'h18);
    wr(12'h0b8, 1);
    wirq;
    wr(12'h0b8, 0);
    wr(12'h088, 0);
    wr(12'h0b0, 32'h3f);
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1;
    s_regs;
    s_route;
    s_cadence;
    s_zero;
    s_ring;
    conclude;
  end
endmodule
